// ===== fsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
package fsc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_ACC_NS      = 90;
  localparam int PHASE_CYC     = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RST_WAIT_US = 10;
  localparam int RST_WAIT_CYC  = (T_RST_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC      = 2;
  localparam int CNT_W         = 10;
  // ---------------------------------------------------------------
  // Register map (byte offsets) and control fields
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_GO      = 3;
  localparam int CTRL_BYTE    = 4;
  localparam int CTRL_ERASING = 5;
  localparam int ADDR_AM1     = 18;
  localparam int ST_BUSY      = 0;
  localparam int ST_PASS      = 1;
  localparam int ST_FAIL      = 2;
  localparam int ST_REFUSED   = 3;
  localparam int ST_WORD_LSB  = 8;
  // ---------------------------------------------------------------
  // Operations and flash constants
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_READ  = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_CMD   = 3'h2;
  localparam logic [2:0] OP_RESET = 3'h3;
  localparam logic [2:0] OP_TPOLL = 3'h4;
  localparam logic [17:0] UNLOCK_A1   = 18'h0_5555;
  localparam logic [17:0] UNLOCK_A2   = 18'h0_2AAA;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_RESET   = 16'h00F0;
  localparam logic [7:0]  STATUS_MASK = 8'hEC;
  localparam int BIT_TOG1 = 6;
  localparam int BIT_ERR  = 5;
  localparam logic [2:0] MIN_PULSES = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WLOW  = 3'b010,
    ST_WHIGH = 3'b011,
    ST_RLOW  = 3'b100,
    ST_RGAP  = 3'b101,
    ST_WAIT  = 3'b110
  } fsc_state_t;
endpackage

module fsc_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    q_out  <= meta_r;
  end
endmodule
`default_nettype wire

// ===== fsc_ctrl.sv
// Behaviour
// - Poll only after fourth or sixth write; the code accepts a poll after four or more write pulses
// - Poll at programmed or erasing address
// - Two equal toggles mean done
// - Unlock: AAh then 55h at addresses
// - Wait 10us after reset during erase
// - Mask reserved status bits 0, 1, 4
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fsc_ctrl (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output var  logic [31:0] WB_DAT_OUT,
  output var  logic        WB_ACK_OUT,
  output var  logic [17:0] FL_ADDR_OUT,
  output var  logic        FL_AM1_OUT,
  output var  logic [15:0] FL_DQ_OUT,
  output var  logic        FL_DQ_OE_OUT,
  input  wire logic [15:0] FL_DQ_IN,
  output var  logic        FL_CE_N_OUT,
  output var  logic        FL_OE_N_OUT,
  output var  logic        FL_WE_N_OUT,
  output var  logic        FL_BYTE_N_OUT
);
  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [5:0]  ctrl_r;
  logic [18:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic        busy_r, pass_r, fail_r, refused_r;
  wire         wb_req  = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
  wire         wb_wr   = wb_req & WB_WE_IN;
  wire  [31:0] wmask   = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}},
                          {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
  wire  [31:0] wr_val_ctrl  = ({26'h0, ctrl_r} & ~wmask) | (WB_DAT_IN & wmask);
  wire  [31:0] wr_val_addr  = ({13'h0, addr_r} & ~wmask) | (WB_DAT_IN & wmask);
  wire  [31:0] wr_val_wdata = ({16'h0, wdata_r} & ~wmask) | (WB_DAT_IN & wmask);
  wire  [7:0]  status_word  = rdata_r[7:0] & fsc_pkg::STATUS_MASK;
  wire  [31:0] status_val   = {16'h0, status_word, 4'h0,
                               refused_r, fail_r, pass_r, busy_r};
  wire         go_wr = wb_wr && WB_ADR_IN == fsc_pkg::REG_CTRL &&
                       wr_val_ctrl[fsc_pkg::CTRL_GO];
  wire  [31:0] rd_mux =
    (WB_ADR_IN == fsc_pkg::REG_CTRL)   ? {26'h0, ctrl_r} :
    (WB_ADR_IN == fsc_pkg::REG_ADDR)   ? {13'h0, addr_r} :
    (WB_ADR_IN == fsc_pkg::REG_WDATA)  ? {16'h0, wdata_r} :
    (WB_ADR_IN == fsc_pkg::REG_STATUS) ? status_val :
    (WB_ADR_IN == fsc_pkg::REG_RDATA)  ? {16'h0, rdata_r} : 32'h0000_0000;

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      WB_ACK_OUT <= wb_req;
      WB_DAT_OUT <= rd_mux;
    end
  end

  // Settings are frozen while busy so a sequence never changes mid-way
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      ctrl_r  <= 6'h00;
      addr_r  <= 19'h0_0000;
      wdata_r <= 16'h0000;
    end else if (wb_wr && !busy_r) begin
      if (WB_ADR_IN == fsc_pkg::REG_CTRL)
        ctrl_r <= {wr_val_ctrl[5:4], 1'b0, wr_val_ctrl[2:0]};
      if (WB_ADR_IN == fsc_pkg::REG_ADDR)
        addr_r <= wr_val_addr[18:0];
      if (WB_ADR_IN == fsc_pkg::REG_WDATA)
        wdata_r <= wr_val_wdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Flash sequencer
  // ---------------------------------------------------------------
  fsc_pkg::fsc_state_t state_r;
  logic [fsc_pkg::CNT_W-1:0] cnt_r;
  logic [1:0]  step_r;
  logic [2:0]  op_r;
  logic [2:0]  pulses_r;
  logic [7:0]  prev_r;
  logic        first_r, final_r, err_seen_r, cont_r;
  logic [15:0] dq_sync;

  fsc_sync #(
    .W (16)
  ) u_dq_sync (
    .clk_in (CLK_SYS_IN),
    .d_in   (FL_DQ_IN),
    .q_out  (dq_sync)
  );

  wire        byte_mode = ctrl_r[fsc_pkg::CTRL_BYTE];
  wire        is_cmd    = op_r == fsc_pkg::OP_CMD;
  wire        is_rd_op  = op_r == fsc_pkg::OP_READ || op_r == fsc_pkg::OP_TPOLL;
  wire        last_step = !is_cmd || step_r == 2'd2;
  wire        cnt_done  = cnt_r == '0;
  wire [2:0]  sel_op    = wr_val_ctrl[2:0];
  // Unlock pair at A14..A0 only; high lines held low
  wire [17:0] step_addr = !is_cmd       ? addr_r[17:0] :
                          (step_r == 2'd1) ? fsc_pkg::UNLOCK_A2 : fsc_pkg::UNLOCK_A1;
  wire        step_am1  = byte_mode & (is_cmd ? (step_r == 2'd1) : addr_r[fsc_pkg::ADDR_AM1]);
  wire [15:0] step_data = (is_cmd && step_r == 2'd0) ? fsc_pkg::CMD_UNLOCK1 :
                          (is_cmd && step_r == 2'd1) ? fsc_pkg::CMD_UNLOCK2 :
                          (op_r == fsc_pkg::OP_RESET) ? fsc_pkg::CMD_RESET : wdata_r;
  wire        tog_same  = dq_sync[fsc_pkg::BIT_TOG1] == prev_r[fsc_pkg::BIT_TOG1];
  wire        early     = sel_op == fsc_pkg::OP_TPOLL && pulses_r < fsc_pkg::MIN_PULSES;

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      state_r <= fsc_pkg::ST_IDLE;
      cnt_r <= '0;
      step_r <= 2'd0;
      op_r <= fsc_pkg::OP_READ;
      pulses_r <= 3'h0;
      prev_r <= 8'h00;
      rdata_r <= 16'h0000;
      {first_r, final_r, err_seen_r, cont_r} <= 4'h0;
      {busy_r, pass_r, fail_r, refused_r} <= 4'h0;
      {FL_CE_N_OUT, FL_OE_N_OUT, FL_WE_N_OUT} <= 3'b111;
      FL_DQ_OE_OUT <= 1'b0;
      FL_DQ_OUT <= 16'h0000;
      FL_ADDR_OUT <= 18'h0_0000;
      FL_AM1_OUT <= 1'b0;
      FL_BYTE_N_OUT <= 1'b1;
    end else begin
      FL_BYTE_N_OUT <= ~byte_mode;
      unique case (state_r)
        fsc_pkg::ST_IDLE: if (go_wr) begin
          if (early) begin
            refused_r <= 1'b1;
          end else begin
            {busy_r, pass_r, fail_r, refused_r} <= 4'b1000;
            op_r <= sel_op;
            step_r <= 2'd0;
            {first_r, final_r, err_seen_r} <= 3'b100;
            cnt_r <= fsc_pkg::CNT_W'(fsc_pkg::PHASE_CYC);
            state_r <= fsc_pkg::ST_SETUP;
          end
        end
        fsc_pkg::ST_SETUP: begin
          FL_CE_N_OUT <= 1'b0;
          FL_ADDR_OUT <= step_addr;
          FL_AM1_OUT <= step_am1;
          FL_DQ_OUT <= step_data;
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            if (is_rd_op) begin
              FL_OE_N_OUT <= 1'b0;
              cnt_r <= fsc_pkg::CNT_W'(fsc_pkg::PHASE_CYC + fsc_pkg::SYNC_CYC);
              state_r <= fsc_pkg::ST_RLOW;
            end else begin
              FL_WE_N_OUT <= 1'b0;
              FL_DQ_OE_OUT <= 1'b1;
              cnt_r <= fsc_pkg::CNT_W'(fsc_pkg::PHASE_CYC);
              state_r <= fsc_pkg::ST_WLOW;
            end
          end
        end
        fsc_pkg::ST_WLOW: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            FL_WE_N_OUT <= 1'b1;
            cnt_r <= fsc_pkg::CNT_W'(fsc_pkg::PHASE_CYC);
            state_r <= fsc_pkg::ST_WHIGH;
          end
        end
        fsc_pkg::ST_WHIGH: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            FL_DQ_OE_OUT <= 1'b0;
            FL_CE_N_OUT <= 1'b1;
            if (pulses_r != 3'h7)
              pulses_r <= pulses_r + 1'b1;
            if (!last_step) begin
              step_r <= step_r + 1'b1;
              cnt_r <= fsc_pkg::CNT_W'(fsc_pkg::PHASE_CYC);
              state_r <= fsc_pkg::ST_SETUP;
            end else if (op_r == fsc_pkg::OP_RESET && ctrl_r[fsc_pkg::CTRL_ERASING]) begin
              pulses_r <= 3'h0;
              cnt_r <= fsc_pkg::CNT_W'(fsc_pkg::RST_WAIT_CYC);
              state_r <= fsc_pkg::ST_WAIT;
            end else begin
              if (op_r == fsc_pkg::OP_RESET)
                pulses_r <= 3'h0;
              {busy_r, pass_r} <= 2'b01;
              state_r <= fsc_pkg::ST_IDLE;
            end
          end
        end
        fsc_pkg::ST_RLOW: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            // The device advances its toggle bits on each falling OE, so OE is raised between reads
            {FL_CE_N_OUT, FL_OE_N_OUT} <= 2'b11;
            cnt_r <= fsc_pkg::CNT_W'(fsc_pkg::PHASE_CYC);
            state_r <= fsc_pkg::ST_RGAP;
            prev_r <= dq_sync[7:0];
            first_r <= 1'b0;
            cont_r <= 1'b0;
            if (op_r == fsc_pkg::OP_READ || final_r) begin
              rdata_r <= dq_sync;
              pass_r <= 1'b1;
              if (final_r)
                pulses_r <= 3'h0;
            end else if (first_r) begin
              cont_r <= 1'b1;
            end else if (tog_same) begin
              final_r <= 1'b1;
              cont_r <= 1'b1;
            end else if (dq_sync[fsc_pkg::BIT_ERR] && err_seen_r) begin
              // Still toggling after the error bit rose: give up
              rdata_r <= dq_sync;
              fail_r <= 1'b1;
              pulses_r <= 3'h0;
            end else begin
              err_seen_r <= err_seen_r | dq_sync[fsc_pkg::BIT_ERR];
              cont_r <= 1'b1;
            end
          end
        end
        fsc_pkg::ST_RGAP: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            cnt_r <= fsc_pkg::CNT_W'(fsc_pkg::PHASE_CYC);
            state_r <= cont_r ? fsc_pkg::ST_SETUP : fsc_pkg::ST_IDLE;
            busy_r <= cont_r;
          end
        end
        fsc_pkg::ST_WAIT: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            {busy_r, pass_r} <= 2'b01;
            state_r <= fsc_pkg::ST_IDLE;
          end
        end
        default: state_r <= fsc_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);

  logic [fsc_pkg::CNT_W-1:0] wait_seen_r;
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN || state_r != fsc_pkg::ST_WAIT)
      wait_seen_r <= '0;
    else
      wait_seen_r <= wait_seen_r + 1'b1;
  end

  sequence s_unlock1;
    !FL_WE_N_OUT && FL_DQ_OUT == fsc_pkg::CMD_UNLOCK1 && FL_ADDR_OUT == fsc_pkg::UNLOCK_A1;
  endsequence
  sequence s_unlock2;
    !FL_WE_N_OUT && FL_DQ_OUT == fsc_pkg::CMD_UNLOCK2 && FL_ADDR_OUT == fsc_pkg::UNLOCK_A2;
  endsequence

  a_unlock_order: assert property (
    (is_cmd && state_r == fsc_pkg::ST_WLOW && step_r == 2'd0) |-> s_unlock1
      ##[1:40] s_unlock2)
    else $error("unlock pair not issued in order");
  a_early_poll: assert property (
    (state_r == fsc_pkg::ST_IDLE && go_wr && early) |=> refused_r && !busy_r)
    else $error("poll started before enough write pulses");
  a_poll_addr: assert property (
    (op_r == fsc_pkg::OP_TPOLL && !FL_OE_N_OUT) |-> FL_ADDR_OUT == addr_r[17:0])
    else $error("poll read away from target address");
  a_reset_wait: assert property (
    (state_r == fsc_pkg::ST_WAIT && $past(state_r) == fsc_pkg::ST_WHIGH) |->
      busy_r [*8] ##1 (wait_seen_r < fsc_pkg::CNT_W'(fsc_pkg::RST_WAIT_CYC) || !busy_r))
    else $error("reset recovery wait cut short");
  a_wait_len: assert property (
    $fell(state_r == fsc_pkg::ST_WAIT) |-> $past(wait_seen_r) ==
      fsc_pkg::CNT_W'(fsc_pkg::RST_WAIT_CYC))
    else $error("reset recovery wait has wrong length");
  a_done_equal: assert property (
    (op_r == fsc_pkg::OP_TPOLL && $rose(pass_r)) |-> $past(final_r))
    else $error("poll passed without two equal toggle reads");
  a_mask_rsvd: assert property (
    (status_val[fsc_pkg::ST_WORD_LSB+4] == 1'b0) &&
    (status_val[fsc_pkg::ST_WORD_LSB+1 -: 2] == 2'b00))
    else $error("reserved status bits not masked");
  a_no_clash: assert property (
    !(!FL_WE_N_OUT && !FL_OE_N_OUT) && (!FL_DQ_OE_OUT || FL_OE_N_OUT))
    else $error("write and read strobes overlap");
  a_ack_pulse: assert property (
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("bus ack held for more than one cycle");
endmodule
`default_nettype wire

// ===== fsc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_flash_model #(
  // Arbitrary identification values
  parameter logic [15:0] MAKER_CODE = 16'h003C,
  parameter logic [15:0] PART_CODE  = 16'h00C3
) (
  input  wire logic [17:0] addr_in,
  input  wire logic        am1_in,
  input  wire logic [15:0] dq_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [3:0]  busy_reads_in,
  input  wire logic        fail_in,
  output var  logic [15:0] dq_out
);
  logic [15:0] cell_r = 16'h0000;
  logic [15:0] last_r = 16'h0000;
  logic [17:0] wa [0:31];
  logic [15:0] wd [0:31];
  logic        wm [0:31];
  int          nw    = 0;
  int          busy  = 0;
  logic        tog   = 1'b0;
  logic        err   = 1'b0;
  logic        prog  = 1'b0;
  logic        ident = 1'b0;
  logic        ers   = 1'b0;
  logic        epend = 1'b0;
  logic        rd;
  // ---------------------------------------------------------------
  // Writes land on the rising write enable
  // ---------------------------------------------------------------
  always @(posedge we_n_in) begin
    if (!ce_n_in) begin
      wa[nw % 32] = addr_in;
      wd[nw % 32] = dq_in;
      wm[nw % 32] = am1_in;
      nw = nw + 1;
      if (prog) begin
        cell_r = dq_in;
        busy = busy_reads_in;
        err = fail_in;
        prog = 1'b0;
        ers = 1'b0;
      end else if (dq_in[7:0] == 8'hF0) begin
        ident = 1'b0;
        busy = 0;
        err = 1'b0;
        epend = 1'b0;
      end else if (epend && dq_in[7:0] == 8'h10) begin
        // Whole-array erase: every address lies in the block under erase
        cell_r = 16'hFFFF;
        busy = busy_reads_in;
        ers = 1'b1;
        err = 1'b0;
        epend = 1'b0;
      end else begin
        // Only A0h arms a program; anything else leaves none pending
        prog = (dq_in[7:0] == 8'hA0);
        if (dq_in[7:0] == 8'h90) ident = 1'b1;
        // Unlock writes keep an erase set-up open, so the pair may come 4th and 5th
        if (dq_in[7:0] != 8'hAA && dq_in[7:0] != 8'h55)
          epend = (dq_in[7:0] == 8'h80);
      end
    end
  end
  // ---------------------------------------------------------------
  // Reads
  // ---------------------------------------------------------------
  always @(negedge oe_n_in) begin
    if (!ce_n_in && busy > 0) begin
      tog = ~tog;
      // A failed program never completes
      if (!err) busy = busy - 1;
    end
  end
  assign rd = !ce_n_in && !oe_n_in;
  always @* begin
    if (rd && busy > 0 && ers) dq_out = {8'h00, 1'b0, tog, err, 2'b01, tog, 2'b00};
    else if (rd && busy > 0) dq_out = {8'h00, ~cell_r[7], tog, err, 3'b001, 2'b00};
    // Blocks with the top address line high count as protected
    else if (rd && ident && addr_in[1]) dq_out = {15'h0000, addr_in[17]};
    else if (rd && ident) dq_out = addr_in[0] ? PART_CODE : MAKER_CODE;
    else if (rd) dq_out = cell_r;
    else dq_out = ~last_r;
  end
  // Released bus shows the inverse so stale data is never trusted
  always @(dq_out) if (rd) last_r = dq_out;
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, st;
  logic [31:0] dat_o;
  logic        ack, am1, dq_oe, ce_n, oe_n, we_n, byte_n, fail = 1'b0;
  logic [17:0] fa;
  logic [15:0] dq_c, dq_m, dq_w;
  logic [3:0]  nbusy = 4'h6;
  logic [3:0]  sel = 4'hF;
  int          bad_count = 0, compares = 0;
  always #12.5 clk = ~clk;
  assign dq_w = dq_oe ? dq_c : dq_m;
  fsc_ctrl uut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(dat_o),
    .WB_ACK_OUT(ack), .FL_ADDR_OUT(fa), .FL_AM1_OUT(am1), .FL_DQ_OUT(dq_c),
    .FL_DQ_OE_OUT(dq_oe), .FL_DQ_IN(dq_w), .FL_CE_N_OUT(ce_n), .FL_OE_N_OUT(oe_n),
    .FL_WE_N_OUT(we_n), .FL_BYTE_N_OUT(byte_n));
  fsc_flash_model flash (.addr_in(fa), .am1_in(am1), .dq_in(dq_w), .ce_n_in(ce_n),
    .oe_n_in(oe_n), .we_n_in(we_n), .busy_reads_in(nbusy), .fail_in(fail), .dq_out(dq_m));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  // Ack and read data are taken at the edge where ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic run_op(input logic [2:0] op, input logic bm);
    int n;
    wb(1'b1, fsc_pkg::REG_CTRL, {27'h0, bm, 1'b1, op});
    n = 0;
    do begin
      wb(1'b0, fsc_pkg::REG_STATUS, 32'h0000_0000);
      n++;
    end while (rdat[fsc_pkg::ST_BUSY] !== 1'b0 && n < 400);
    st = rdat;
    if (n >= 400) begin
      bad_count++;
      give_verdict();
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("ce_n", 32'h1, {31'h0, ce_n});
    check("byte_n", 32'h1, {31'h0, byte_n});
    wb(1'b0, fsc_pkg::REG_STATUS, 32'h0000_0000);
    check("status", 32'h0000_0000, rdat);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped", 32'h0000_0000, rdat);
    sel <= 4'h1;
    wb(1'b1, fsc_pkg::REG_ADDR, 32'hFFFF_FFFF);
    sel <= 4'hF;
    wb(1'b0, fsc_pkg::REG_ADDR, 32'h0000_0000);
    check("byte lane", 32'h0000_00FF, rdat);
  endtask
  task automatic t_unlock(input logic bm);
    int b;
    logic [7:0] e;
    b = flash.nw;
    wb(1'b1, fsc_pkg::REG_WDATA, 32'h0000_0090);
    run_op(fsc_pkg::OP_CMD, bm);
    check("byte_n mode", {31'h0, !bm}, {31'h0, byte_n});
    check("addr1", {14'h0, fsc_pkg::UNLOCK_A1}, {14'h0, flash.wa[b]});
    check("addr2", {14'h0, fsc_pkg::UNLOCK_A2}, {14'h0, flash.wa[b+1]});
    check("addr3", {14'h0, fsc_pkg::UNLOCK_A1}, {14'h0, flash.wa[b+2]});
    check("am1", {29'h0, 1'b0, bm, 1'b0}, {29'h0, flash.wm[b], flash.wm[b+1], flash.wm[b+2]});
    check("data", 32'h00AA_5590, {8'h00, flash.wd[b][7:0], flash.wd[b+1][7:0], flash.wd[b+2][7:0]});
    // Fourth read addresses a protected block
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, fsc_pkg::REG_ADDR, (i > 2) ? 32'h0002_0002 : i);
      run_op(fsc_pkg::OP_READ, bm);
      wb(1'b0, fsc_pkg::REG_RDATA, 32'h0000_0000);
      e = (i == 0) ? 8'h3C : (i == 1) ? 8'hC3 : (i == 2) ? 8'h00 : 8'h01;
      check("ident", {24'h0, e}, {24'h0, rdat[7:0]});
    end
    run_op(fsc_pkg::OP_RESET, bm);
    check("reset data", 32'h0000_00F0, {24'h0, flash.wd[b+3][7:0]});
  endtask
  task automatic t_program(input logic [15:0] d, input logic f);
    fail <= f;
    wb(1'b1, fsc_pkg::REG_WDATA, 32'h0000_00A0);
    run_op(fsc_pkg::OP_CMD, 1'b0);
    wb(1'b1, fsc_pkg::REG_ADDR, 32'h0000_0123);
    wb(1'b1, fsc_pkg::REG_WDATA, {16'h0, d});
    run_op(fsc_pkg::OP_WRITE, 1'b0);
    run_op(fsc_pkg::OP_TPOLL, 1'b0);
    check("fail", {31'h0, f}, {31'h0, st[fsc_pkg::ST_FAIL]});
    check("pass", {31'h0, !f}, {31'h0, st[fsc_pkg::ST_PASS]});
    if (!f) begin
      wb(1'b0, fsc_pkg::REG_RDATA, 32'h0000_0000);
      check("final read", {16'h0, d}, rdat);
      check("masked", {24'h0, d[7:0] & fsc_pkg::STATUS_MASK}, {24'h0, st[15:8]});
    end
    run_op(fsc_pkg::OP_RESET, 1'b0);
    run_op(fsc_pkg::OP_READ, 1'b0);
    wb(1'b0, fsc_pkg::REG_RDATA, 32'h0000_0000);
    check("array read", {16'h0, d}, rdat);
  endtask
  task automatic t_erase();
    int n;
    logic [7:0] r1;
    wb(1'b1, fsc_pkg::REG_WDATA, 32'h0000_0080);
    run_op(fsc_pkg::OP_CMD, 1'b0);
    wb(1'b1, fsc_pkg::REG_WDATA, 32'h0000_0010);
    run_op(fsc_pkg::OP_CMD, 1'b0);
    wb(1'b1, fsc_pkg::REG_ADDR, 32'h0000_0123);
    run_op(fsc_pkg::OP_READ, 1'b0);
    wb(1'b0, fsc_pkg::REG_RDATA, 32'h0000_0000);
    r1 = rdat[7:0];
    check("erase status", 32'h0000_0008, {24'h0, rdat[7:0] & 8'hA8});
    run_op(fsc_pkg::OP_READ, 1'b0);
    wb(1'b0, fsc_pkg::REG_RDATA, 32'h0000_0000);
    check("erase toggles", 32'h0000_0044, {24'h0, (rdat[7:0] ^ r1) & 8'h44});
    run_op(fsc_pkg::OP_TPOLL, 1'b0);
    check("erase pass", 32'h1, {31'h0, st[fsc_pkg::ST_PASS]});
    wb(1'b0, fsc_pkg::REG_RDATA, 32'h0000_0000);
    check("erased data", 32'h0000_FFFF, rdat);
    // Reset after an erase: busy must cover the recovery wait
    wb(1'b1, fsc_pkg::REG_CTRL, {26'h0, 1'b1, 1'b0, 1'b1, fsc_pkg::OP_RESET});
    n = 0;
    do begin
      wb(1'b0, fsc_pkg::REG_STATUS, 32'h0000_0000);
      n++;
    end while (rdat[fsc_pkg::ST_BUSY] !== 1'b0 && n < 400);
    check("reset wait", 32'h1, {31'h0, (3 * n >= fsc_pkg::RST_WAIT_CYC &&
      3 * n <= fsc_pkg::RST_WAIT_CYC + 60)});
    check("reset pass", 32'h1, {31'h0, rdat[fsc_pkg::ST_PASS]});
  endtask
  task automatic t_refused();
    run_op(fsc_pkg::OP_TPOLL, 1'b0);
    check("refused", 32'h1, {31'h0, st[fsc_pkg::ST_REFUSED]});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_unlock(1'b0);
    t_unlock(1'b1);
    t_program(16'h005A, 1'b0);
    t_erase();
    t_program(16'h000F, 1'b1);
    t_refused();
    give_verdict();
  end
endmodule
`default_nettype wire
